/* File: src/sleep_gate_pkg.sv */
package sleep_gate_pkg;

    // Register map
    localparam logic [3:0] SLEEP_CONTROL_ADDR = 4'h0;
    localparam logic [3:0] GENERAL_GATE_ADDR = 4'h8;
    localparam logic [3:0] PORT_A_GATE_ADDR = 4'h9;
    localparam logic [3:0] PORT_C_GATE_ADDR = 4'hB;
    localparam logic [3:0] PORT_D_GATE_ADDR = 4'hC;
    localparam logic [3:0] PORT_E_GATE_ADDR = 4'hD;
    localparam logic [3:0] PORT_F_GATE_ADDR = 4'hE;
    localparam logic [3:0] SLEEP_STATUS_ADDR = 4'hF;

    // Writable bit masks
    localparam logic [7:0] SLEEP_CONTROL_MASK = 8'h0F;
    localparam logic [7:0] GENERAL_GATE_MASK = 8'h06;
    localparam logic [7:0] PORT_A_GATE_MASK = 8'h03;
    localparam logic [7:0] PORT_C_GATE_MASK = 8'h5F;
    localparam logic [7:0] PORT_D_GATE_MASK = 8'h19;
    localparam logic [7:0] PORT_E_GATE_MASK = 8'h51;
    localparam logic [7:0] PORT_F_GATE_MASK = 8'h11;
    localparam logic [7:0] REG_RESET = 8'h00;

    // Field positions
    localparam int SLEEP_ARM_BIT = 0;
    localparam int MODE_LSB = 1;
    localparam int GATE_COUNTER_BIT = 2;
    localparam int GATE_EVENT_BIT = 1;
    localparam int GATE_ADC_BIT = 1;
    localparam int GATE_CMP_BIT = 0;
    localparam int GATE_TWI_BIT = 6;
    localparam int GATE_SERIAL_BIT = 4;
    localparam int GATE_SPI_BIT = 3;
    localparam int GATE_FINE_BIT = 2;
    localparam int GATE_T1_BIT = 1;
    localparam int GATE_T0_BIT = 0;

    // Mode codes
    localparam logic [2:0] MODE_IDLE = 3'h0;
    localparam logic [2:0] MODE_FULL_HALT = 3'h2;
    localparam logic [2:0] MODE_COUNTER_KEPT = 3'h3;
    localparam logic [2:0] MODE_OSC_KEPT = 3'h6;
    localparam logic [2:0] MODE_OSC_COUNTER_KEPT = 3'h7;

    // Wake stall
    localparam logic [2:0] WAKE_STALL_CYCLES = 3'h4;

    localparam int PORT_COUNT = 4;

    typedef enum logic [5:0] {
        ST_ACTIVE = 6'h01,
        ST_IDLE = 6'h02,
        ST_FULL_HALT = 6'h04,
        ST_COUNTER_KEPT = 6'h08,
        ST_OSC_KEPT = 6'h10,
        ST_OSC_COUNTER_KEPT = 6'h20
    } power_state_e;

    // Register port request
    typedef struct packed {
        logic [3:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } reg_req_s;

    // Wake sources from the core side
    typedef struct packed {
        logic any_irq;
        logic twi_match;
        logic port_async;
        logic counter_irq;
    } wake_src_s;

    // Peripheral clock enables, one pulse-free level each
    typedef struct packed {
        logic counter_if;
        logic event_router;
        logic adc;
        logic analog_comparator;
        logic [PORT_COUNT-1:0] two_wire_interface;
        logic [PORT_COUNT-1:0] serial_port_zero;
        logic [PORT_COUNT-1:0] spi;
        logic [PORT_COUNT-1:0] fine_resolution_extension;
        logic [PORT_COUNT-1:0] timer_one;
        logic [PORT_COUNT-1:0] timer_zero;
    } clock_enables_s;

    // Domain and analog controls
    typedef struct packed {
        logic cpu_clock_run;
        logic nvm_run;
        logic peripheral_clock_run;
        logic counter_clock_run;
        logic system_osc_run;
        logic counter_osc_run;
        logic adc_auto_off;
        logic cmp_auto_off;
        logic vref_keep;
        logic input_buffers_on;
        logic watchdog_run;
        logic brownout_run;
        logic core_stall;
    } power_ctrl_s;

endpackage : sleep_gate_pkg

/* File: src/gate_register.sv */
`timescale 1ns/1ps
`default_nettype none

module gate_register
    import sleep_gate_pkg::*;
#(
    parameter logic [7:0] MASK = 8'h00
) (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic wr_en,
    input wire logic [7:0] wdata,
    output logic [7:0] value
);
    import sleep_gate_pkg::*;

    typedef struct packed {
        logic [7:0] bits;
    } gate_state_s;

    gate_state_s state_q;
    gate_state_s state_d;

    // Only bits that exist take a write; others stay zero
    always_comb begin
        state_d = state_q;
        if (wr_en) begin
            state_d.bits = wdata & MASK;
        end
    end

    // State register
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= '{bits: REG_RESET};
        end else begin
            state_q <= state_d;
        end
    end

    assign value = state_q.bits;

endmodule : gate_register

`default_nettype wire

/* File: src/sleep_and_clock_gating.sv */
// How it works
// - Gate bit set stops that peripheral clock and blocks its register access.
// - Clearing a gate bit restarts the clock; peripheral resumes frozen state.
// - Gate bits for absent peripherals store nothing and drive nothing.
// - Gate bits only matter in active and idle; deeper modes stop every gated peripheral clock.
// - Mode field bits 3:1 decode idle, halt, counter, osc, osc+counter.
// - Sleep request enters sleep only while the arm bit 0 is set.
// - Reserved bits read zero and ignore writes.
// - General bit 2 stops counter interface; counter itself keeps counting.
// - General bit 1 stops the event router; clearing resumes it.
// - Port A bit 1 gates the ADC, bit 0 the comparator core.
// - Port gates: 6 two-wire, 4 serial, 3 SPI, 2 fine, 1 timer1, 0 timer0.
// - Timer one resumes where it stopped when ungated.
// - Some port bits exist only in port C and D, some only in C.
// - ADC switched off in all sleep modes but idle; flags extended conversion.
// - Comparator off in all sleep modes but idle; its reference kept only while comparator enabled and using it.
// - Input buffers off whenever the peripheral clock is stopped by sleep.
// - An enabled watchdog keeps running in every sleep mode.
// - Fused brownout stays on; deeper modes may sample it instead.
// - With debug enabled, sleep keeps the main clock source running.
// - On wake the core stalls four cycles before resuming.
// - Idle stops core and memory; peripherals run; any interrupt wakes.
// - Full halt stops all clocks; only two-wire match or port interrupt wake.
// - Counter-kept modes run the counter; osc-kept modes keep the system oscillator.
`timescale 1ns/1ps
`default_nettype none

module sleep_and_clock_gating (
    input wire logic mclk,
    input wire logic reset_n,
    input wire sleep_gate_pkg::reg_req_s reg_req,
    output logic [7:0] reg_rdata,
    input wire logic sleep_request,
    input wire sleep_gate_pkg::wake_src_s wake_src,
    input wire logic watchdog_enabled,
    input wire logic brownout_fused,
    input wire logic brownout_sampled_mode,
    input wire logic debug_enabled,
    input wire logic comparator_enabled,
    input wire logic comparator_uses_vref,
    output sleep_gate_pkg::clock_enables_s clock_enables,
    output sleep_gate_pkg::power_ctrl_s power_ctrl,
    output logic sleep_done,
    output logic sleep_ignored,
    output logic adc_extended_next,
    output logic gated_access_blocked
);
    import sleep_gate_pkg::*;

    //////////////////////////////////////////////////////////////////////////
    // Reset release

    logic [1:0] rst_sync_q;
    logic rst_n;

    // Two-stage release of the asynchronous reset
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            rst_sync_q <= 2'h0;
        end else begin
            rst_sync_q <= {rst_sync_q[0], 1'b1};
        end
    end

    assign rst_n = rst_sync_q[1];

    //////////////////////////////////////////////////////////////////////////
    // Gating registers

    logic [7:0] gen_gate;
    logic [7:0] pa_gate;
    logic [7:0] port_gate [PORT_COUNT];
    logic [3:0] port_addr [PORT_COUNT];

    assign port_addr[0] = PORT_C_GATE_ADDR;
    assign port_addr[1] = PORT_D_GATE_ADDR;
    assign port_addr[2] = PORT_E_GATE_ADDR;
    assign port_addr[3] = PORT_F_GATE_ADDR;

    gate_register #(.MASK(GENERAL_GATE_MASK)) u_gen_gate (
        .mclk(mclk),
        .rst_n(rst_n),
        .wr_en(reg_req.wr && reg_req.addr == GENERAL_GATE_ADDR),
        .wdata(reg_req.wdata),
        .value(gen_gate)
    );

    gate_register #(.MASK(PORT_A_GATE_MASK)) u_pa_gate (
        .mclk(mclk),
        .rst_n(rst_n),
        .wr_en(reg_req.wr && reg_req.addr == PORT_A_GATE_ADDR),
        .wdata(reg_req.wdata),
        .value(pa_gate)
    );

    // One register per port; absent bits are masked per port
    generate
        for (genvar p = 0; p < PORT_COUNT; p++) begin : g_port
            localparam logic [7:0] PMASK = (p == 0) ? PORT_C_GATE_MASK :
                                           (p == 1) ? PORT_D_GATE_MASK :
                                           (p == 2) ? PORT_E_GATE_MASK : PORT_F_GATE_MASK;
            gate_register #(.MASK(PMASK)) u_port_gate (
                .mclk(mclk),
                .rst_n(rst_n),
                .wr_en(reg_req.wr && reg_req.addr == port_addr[p]),
                .wdata(reg_req.wdata),
                .value(port_gate[p])
            );
        end
    endgenerate

    //////////////////////////////////////////////////////////////////////////
    // Sleep state

    typedef struct packed {
        logic [7:0] sleep_ctrl;
        power_state_e pstate;
        logic [2:0] stall_cnt;
        logic [7:0] rdata;
        logic sleep_done;
        logic sleep_ignored;
        logic adc_was_off;
        logic adc_extended;
        logic blocked;
        clock_enables_s ce;
        power_ctrl_s pc;
    } core_state_s;

    core_state_s s_q;
    core_state_s s_d;

    logic [2:0] mode_sel;
    logic wake;
    logic periph_run;
    logic asleep;
    logic in_idle;
    logic [7:0] gate_read;
    logic gate_hit;

    assign mode_sel = s_q.sleep_ctrl[MODE_LSB +: 3];
    assign asleep = s_q.pstate != ST_ACTIVE;
    assign in_idle = s_q.pstate == ST_IDLE;

    // Wake sources allowed per mode
    always_comb begin
        wake = 1'b0;
        unique case (s_q.pstate)
            ST_ACTIVE: wake = 1'b0;
            ST_IDLE: wake = wake_src.any_irq;
            ST_FULL_HALT, ST_OSC_KEPT: wake = wake_src.twi_match | wake_src.port_async;
            ST_COUNTER_KEPT, ST_OSC_COUNTER_KEPT: begin
                wake = wake_src.twi_match | wake_src.port_async | wake_src.counter_irq;
            end
        endcase
    end

    // Read mux for gate registers
    always_comb begin
        gate_read = 8'h00;
        gate_hit = 1'b0;
        if (reg_req.addr == GENERAL_GATE_ADDR) begin
            gate_read = gen_gate;
            gate_hit = 1'b1;
        end else if (reg_req.addr == PORT_A_GATE_ADDR) begin
            gate_read = pa_gate;
            gate_hit = 1'b1;
        end
        for (int p = 0; p < PORT_COUNT; p++) begin
            if (reg_req.addr == port_addr[p]) begin
                gate_read = port_gate[p];
                gate_hit = 1'b1;
            end
        end
    end

    assign periph_run = (s_q.pstate == ST_ACTIVE) || in_idle;

    // Next-state logic
    always_comb begin
        s_d = s_q;
        s_d.sleep_done = 1'b0;
        s_d.sleep_ignored = 1'b0;
        // Register port
        if (reg_req.wr && reg_req.addr == SLEEP_CONTROL_ADDR) begin
            s_d.sleep_ctrl = reg_req.wdata & SLEEP_CONTROL_MASK;
        end
        s_d.rdata = 8'h00;
        if (reg_req.rd) begin
            if (reg_req.addr == SLEEP_CONTROL_ADDR) begin
                s_d.rdata = s_q.sleep_ctrl;
            end else if (reg_req.addr == SLEEP_STATUS_ADDR) begin
                s_d.rdata = {2'h0, s_q.pstate};
            end else if (gate_hit) begin
                s_d.rdata = gate_read;
            end
        end
        // Power state sequencing
        unique case (s_q.pstate)
            ST_ACTIVE: begin
                if (s_q.stall_cnt != 3'h0) begin
                    s_d.stall_cnt = s_q.stall_cnt - 3'h1;
                    if (s_q.stall_cnt == 3'h1) begin
                        s_d.sleep_done = 1'b1;
                    end
                end else if (sleep_request) begin
                    if (!s_q.sleep_ctrl[SLEEP_ARM_BIT]) begin
                        s_d.sleep_ignored = 1'b1;
                    end else begin
                        unique case (mode_sel)
                            MODE_IDLE: s_d.pstate = ST_IDLE;
                            MODE_FULL_HALT: s_d.pstate = ST_FULL_HALT;
                            MODE_COUNTER_KEPT: s_d.pstate = ST_COUNTER_KEPT;
                            MODE_OSC_KEPT: s_d.pstate = ST_OSC_KEPT;
                            MODE_OSC_COUNTER_KEPT: s_d.pstate = ST_OSC_COUNTER_KEPT;
                            default: s_d.sleep_ignored = 1'b1;
                        endcase
                    end
                end
            end
            ST_IDLE, ST_FULL_HALT, ST_COUNTER_KEPT, ST_OSC_KEPT, ST_OSC_COUNTER_KEPT: begin
                if (wake) begin
                    s_d.pstate = ST_ACTIVE;
                    s_d.stall_cnt = WAKE_STALL_CYCLES;
                end
            end
        endcase
        // Access to a gated peripheral is refused by the bus fabric
        s_d.blocked = |gen_gate | |pa_gate;
        for (int p = 0; p < PORT_COUNT; p++) begin
            if (|port_gate[p]) begin
                s_d.blocked = 1'b1;
            end
        end
        // Peripheral clock enables; clearing the bit resumes the frozen state
        s_d.ce.counter_if = periph_run & ~gen_gate[GATE_COUNTER_BIT];
        s_d.ce.event_router = periph_run & ~gen_gate[GATE_EVENT_BIT];
        s_d.ce.adc = periph_run & ~pa_gate[GATE_ADC_BIT];
        s_d.ce.analog_comparator = periph_run & ~pa_gate[GATE_CMP_BIT];
        for (int p = 0; p < PORT_COUNT; p++) begin
            s_d.ce.two_wire_interface[p] = periph_run & ~port_gate[p][GATE_TWI_BIT];
            s_d.ce.serial_port_zero[p] = periph_run & ~port_gate[p][GATE_SERIAL_BIT];
            s_d.ce.spi[p] = periph_run & ~port_gate[p][GATE_SPI_BIT];
            s_d.ce.fine_resolution_extension[p] = periph_run & ~port_gate[p][GATE_FINE_BIT];
            s_d.ce.timer_one[p] = periph_run & ~port_gate[p][GATE_T1_BIT];
            s_d.ce.timer_zero[p] = periph_run & ~port_gate[p][GATE_T0_BIT];
        end
        // Domain controls
        s_d.pc.cpu_clock_run = !asleep && s_q.stall_cnt == 3'h0;
        s_d.pc.core_stall = !asleep && s_q.stall_cnt != 3'h0;
        s_d.pc.nvm_run = !asleep;
        s_d.pc.peripheral_clock_run = periph_run;
        s_d.pc.counter_clock_run = periph_run || s_q.pstate == ST_COUNTER_KEPT ||
                                   s_q.pstate == ST_OSC_COUNTER_KEPT;
        s_d.pc.counter_osc_run = s_d.pc.counter_clock_run;
        s_d.pc.system_osc_run = periph_run || s_q.pstate == ST_OSC_KEPT ||
                                s_q.pstate == ST_OSC_COUNTER_KEPT || debug_enabled;
        s_d.pc.adc_auto_off = !periph_run;
        s_d.pc.cmp_auto_off = !periph_run;
        s_d.pc.vref_keep = comparator_enabled && comparator_uses_vref;
        s_d.pc.input_buffers_on = periph_run;
        s_d.pc.watchdog_run = watchdog_enabled;
        s_d.pc.brownout_run = brownout_fused && !(asleep && !in_idle && brownout_sampled_mode);
        // ADC off-then-on forces an extended next conversion
        s_d.adc_was_off = !s_d.ce.adc || s_d.pc.adc_auto_off;
        if (s_q.adc_was_off && !s_d.adc_was_off) begin
            s_d.adc_extended = 1'b1;
        end else if (s_d.adc_was_off) begin
            s_d.adc_extended = 1'b0;
        end
    end

    // State register
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            s_q <= '{sleep_ctrl: REG_RESET, pstate: ST_ACTIVE, stall_cnt: 3'h0, rdata: 8'h00,
                     sleep_done: 1'b0, sleep_ignored: 1'b0, adc_was_off: 1'b0, adc_extended: 1'b0,
                     blocked: 1'b0, ce: '1, pc: 13'h1F80};
        end else begin
            s_q <= s_d;
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // Outputs

    assign reg_rdata = s_q.rdata;
    assign clock_enables = s_q.ce;
    assign power_ctrl = s_q.pc;
    assign sleep_done = s_q.sleep_done;
    assign sleep_ignored = s_q.sleep_ignored;
    assign adc_extended_next = s_q.adc_extended;
    assign gated_access_blocked = s_q.blocked;

endmodule : sleep_and_clock_gating

`default_nettype wire

/* File: verif/sleep_gate_monitor.sv */
`timescale 1ns/1ps
`default_nettype none

module sleep_gate_checker (
    input wire logic mclk,
    input wire logic reset_n,
    input wire sleep_gate_pkg::reg_req_s reg_req,
    input wire logic [7:0] reg_rdata,
    input wire logic sleep_request,
    input wire logic watchdog_enabled,
    input wire logic debug_enabled,
    input wire sleep_gate_pkg::clock_enables_s clock_enables,
    input wire sleep_gate_pkg::power_ctrl_s power_ctrl,
    input wire logic sleep_done,
    input wire logic sleep_ignored
);
    import sleep_gate_pkg::*;
    logic [3:0] live_q;
    logic arm_q;
    logic [2:0] mode_q;
    logic ready;
    logic taken;
    logic bad_mode;

    // Settle window after reset and shadow of the sleep control
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            live_q <= 4'h0;
            arm_q <= 1'b0;
            mode_q <= 3'h0;
        end else begin
            live_q <= {live_q[2:0], 1'b1};
            if (reg_req.wr && reg_req.addr == SLEEP_CONTROL_ADDR) begin
                arm_q <= reg_req.wdata[SLEEP_ARM_BIT];
                mode_q <= reg_req.wdata[3:1];
            end
        end
    end

    // Sleep request seen while the core runs
    assign ready = live_q[3];
    assign taken = sleep_request && power_ctrl.cpu_clock_run && !power_ctrl.core_stall;
    assign bad_mode = mode_q inside {3'h1, 3'h4, 3'h5};

    default clocking @(posedge mclk); endclocking
    default disable iff (!ready);

    sequence stall_run;
        power_ctrl.core_stall [*3] ##1 (power_ctrl.core_stall && sleep_done) ##1
            (!power_ctrl.core_stall && power_ctrl.cpu_clock_run);
    endsequence

    ////////////////////////////////////////////////////////////////
    a_wake_stall_four: assert property ($rose(power_ctrl.core_stall) |-> stall_run)
        else $error("wake stall length wrong");
    a_read_unmapped: assert property (reg_req.rd && reg_req.addr inside {[4'h1:4'h7], 4'hA} |=> reg_rdata == 8'h00)
        else $error("unmapped read not zero");
    a_refuse_sleep: assert property (taken && (!arm_q || bad_mode) |-> ##[1:2] (sleep_ignored && power_ctrl.cpu_clock_run))
        else $error("bad sleep request not refused");
    a_armed_enter: assert property (taken && arm_q && !bad_mode |-> ##[1:2] !power_ctrl.cpu_clock_run)
        else $error("armed sleep not entered");
    a_buffers_off: assert property (!power_ctrl.peripheral_clock_run |-> !power_ctrl.input_buffers_on)
        else $error("input buffers on in deep sleep");
    a_analog_off: assert property (!power_ctrl.peripheral_clock_run |-> power_ctrl.adc_auto_off && power_ctrl.cmp_auto_off)
        else $error("analog not off in deep sleep");
    a_deep_gates: assert property (!power_ctrl.peripheral_clock_run |-> clock_enables.timer_zero == 4'h0 && !clock_enables.adc)
        else $error("peripheral clock runs in deep sleep");
    a_watchdog_kept: assert property (watchdog_enabled ##1 watchdog_enabled |-> power_ctrl.watchdog_run)
        else $error("watchdog stopped");
    a_debug_osc: assert property (debug_enabled ##1 debug_enabled |-> power_ctrl.system_osc_run)
        else $error("main clock stopped under debug");
endmodule : sleep_gate_checker

bind sleep_and_clock_gating sleep_gate_checker u_checker (
    .mclk(mclk),
    .reset_n(reset_n),
    .reg_req(reg_req),
    .reg_rdata(reg_rdata),
    .sleep_request(sleep_request),
    .watchdog_enabled(watchdog_enabled),
    .debug_enabled(debug_enabled),
    .clock_enables(clock_enables),
    .power_ctrl(power_ctrl),
    .sleep_done(sleep_done),
    .sleep_ignored(sleep_ignored)
);

`default_nettype wire

/* File: verif/core_side_model.sv */
`timescale 1ns/1ps
`default_nettype none

module core_side_model (
    input wire logic mclk,
    input wire logic cpu_run,
    input wire sleep_gate_pkg::wake_src_s wake_mask,
    output sleep_gate_pkg::wake_src_s wake_src
);
    import sleep_gate_pkg::*;
    logic [3:0] quiet_q;

    // Count cycles with the core asleep
    always_ff @(posedge mclk) begin
        if (cpu_run) begin
            quiet_q <= 4'h0;
        end else if (quiet_q != 4'hF) begin
            quiet_q <= quiet_q + 4'h1;
        end
    end

    // Chosen wake levels rise only after a short nap
    assign wake_src = (quiet_q >= 4'h3) ? wake_mask : wake_src_s'(4'h0);
endmodule : core_side_model

`default_nettype wire

/* File: verif/sleep_and_clock_gating_tb.sv */
`timescale 1ns/1ps
`default_nettype none

module sleep_and_clock_gating_tb;
    import sleep_gate_pkg::*;
    logic mclk = 1'b0;
    logic reset_n = 1'b0;
    reg_req_s reg_req = '0;
    logic sleep_request = 1'b0;
    wake_src_s wake_src;
    wake_src_s wake_mask = '0;
    logic watchdog_enabled = 1'b1;
    logic brownout_fused = 1'b1;
    logic brownout_sampled_mode = 1'b0;
    logic debug_enabled = 1'b0;
    logic comparator_enabled = 1'b1;
    logic comparator_uses_vref = 1'b1;
    logic [7:0] reg_rdata;
    clock_enables_s clock_enables;
    power_ctrl_s power_ctrl;
    logic sleep_done, sleep_ignored, adc_extended_next, gated_access_blocked;
    logic seen_ignored;
    int fail_count = 0;
    int cmp_count = 0;
    logic [3:0] reg_addr [7] = '{SLEEP_CONTROL_ADDR, GENERAL_GATE_ADDR, PORT_A_GATE_ADDR,
        PORT_C_GATE_ADDR, PORT_D_GATE_ADDR, PORT_E_GATE_ADDR, PORT_F_GATE_ADDR};
    logic [7:0] reg_mask [7] = '{SLEEP_CONTROL_MASK, GENERAL_GATE_MASK, PORT_A_GATE_MASK,
        PORT_C_GATE_MASK, PORT_D_GATE_MASK, PORT_E_GATE_MASK, PORT_F_GATE_MASK};
    logic [2:0] mode_tab [5] = '{MODE_IDLE, MODE_FULL_HALT, MODE_COUNTER_KEPT, MODE_OSC_KEPT,
        MODE_OSC_COUNTER_KEPT};
    power_state_e state_tab [5] = '{ST_IDLE, ST_FULL_HALT, ST_COUNTER_KEPT, ST_OSC_KEPT, ST_OSC_COUNTER_KEPT};
    logic [3:0] wake_tab [5] = '{4'h8, 4'h4, 4'h1, 4'h2, 4'h1};
    logic [3:0] wrong_tab [5] = '{4'h0, 4'h9, 4'h8, 4'h9, 4'h8};
    logic [2:0] dom_tab [5] = '{3'h7, 3'h0, 3'h2, 3'h1, 3'h3};
    logic [7:0] refuse_tab [4] = '{8'h00, 8'h03, 8'h09, 8'h0B};

    // Clock
    always #4 mclk = ~mclk;

    sleep_and_clock_gating DUT (
        .mclk(mclk),
        .reset_n(reset_n),
        .reg_req(reg_req),
        .reg_rdata(reg_rdata),
        .sleep_request(sleep_request),
        .wake_src(wake_src),
        .watchdog_enabled(watchdog_enabled),
        .brownout_fused(brownout_fused),
        .brownout_sampled_mode(brownout_sampled_mode),
        .debug_enabled(debug_enabled),
        .comparator_enabled(comparator_enabled),
        .comparator_uses_vref(comparator_uses_vref),
        .clock_enables(clock_enables),
        .power_ctrl(power_ctrl),
        .sleep_done(sleep_done),
        .sleep_ignored(sleep_ignored),
        .adc_extended_next(adc_extended_next),
        .gated_access_blocked(gated_access_blocked)
    );

    core_side_model u_core (
        .mclk(mclk),
        .cpu_run(power_ctrl.cpu_clock_run),
        .wake_mask(wake_mask),
        .wake_src(wake_src)
    );

    ////////////////////////////////////////////////////////////////
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            fail_count++;
            $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : chk

    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge mclk);
        reg_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge mclk);
        reg_req.wr <= 1'b0;
    endtask : wr

    task automatic rd_chk(input logic [3:0] a, input logic [7:0] exp);
        @(posedge mclk);
        reg_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge mclk);
        reg_req.rd <= 1'b0;
        #1;
        chk(reg_rdata, exp);
    endtask : rd_chk

    // Write the sleep control, then pulse one sleep request
    task automatic nap(input logic [7:0] ctrl);
        wr(SLEEP_CONTROL_ADDR, ctrl);
        @(posedge mclk);
        sleep_request <= 1'b1;
        @(posedge mclk);
        sleep_request <= 1'b0;
        seen_ignored = 1'b0;
        repeat (3) begin
            #1;
            seen_ignored = seen_ignored | sleep_ignored;
            @(posedge mclk);
        end
    endtask : nap

    // Offer a wake source and wait for the end of the stall
    task automatic wake(input logic [3:0] src);
        int n;
        @(posedge mclk);
        wake_mask <= wake_src_s'(src);
        n = 0;
        while (sleep_done !== 1'b1 && n < 40) begin
            @(posedge mclk);
            #1;
            n++;
        end
        chk({7'h0, sleep_done}, 8'h01);
        wake_mask <= '0;
    endtask : wake

    task automatic end_of_test;
        $display("Comparisons %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : end_of_test

    // Watchdog against a hang
    initial begin
        #100us;
        fail_count++;
        $display("ERROR %0t: run timed out", $time);
        end_of_test();
    end

    // Main sequence
    initial begin
        repeat (3) @(posedge mclk);
        reset_n <= 1'b1;
        repeat (5) @(posedge mclk);
        for (int i = 0; i < 7; i++) begin
            rd_chk(reg_addr[i], REG_RESET);
        end
        rd_chk(SLEEP_STATUS_ADDR, {2'b00, ST_ACTIVE});
        rd_chk(4'h5, 8'h00);
        chk({7'h0, &clock_enables}, 8'h01);
        $display("reset values done");
        for (int i = 0; i < 7; i++) begin
            wr(reg_addr[i], 8'hFF);
            rd_chk(reg_addr[i], reg_mask[i]);
        end
        repeat (3) @(posedge mclk);
        chk({4'h0, clock_enables.counter_if, clock_enables.event_router, clock_enables.adc,
            clock_enables.analog_comparator}, 8'h00);
        chk({clock_enables.two_wire_interface, clock_enables.serial_port_zero}, 8'hA0);
        chk({clock_enables.spi, clock_enables.fine_resolution_extension}, 8'hCE);
        chk({clock_enables.timer_one, clock_enables.timer_zero}, 8'hE0);
        chk({7'h0, gated_access_blocked}, 8'h01);
        for (int i = 0; i < 7; i++) begin
            wr(reg_addr[i], 8'h00);
        end
        repeat (3) @(posedge mclk);
        chk({7'h0, &clock_enables}, 8'h01);
        chk({7'h0, gated_access_blocked}, 8'h00);
        chk({7'h0, adc_extended_next}, 8'h01);
        $display("clock gating done");
        for (int i = 0; i < 5; i++) begin
            nap({4'h0, mode_tab[i], 1'b1});
            chk({7'h0, seen_ignored}, 8'h00);
            rd_chk(SLEEP_STATUS_ADDR, {2'b00, state_tab[i]});
            chk({5'h0, power_ctrl.peripheral_clock_run, power_ctrl.counter_clock_run,
                power_ctrl.system_osc_run}, {5'h0, dom_tab[i]});
            chk({4'h0, power_ctrl.input_buffers_on, power_ctrl.adc_auto_off, power_ctrl.cmp_auto_off,
                power_ctrl.cpu_clock_run}, (i == 0) ? 8'h08 : 8'h06);
            chk({5'h0, power_ctrl.vref_keep, power_ctrl.watchdog_run, power_ctrl.brownout_run}, 8'h07);
            @(posedge mclk);
            wake_mask <= wake_src_s'(wrong_tab[i]);
            repeat (8) @(posedge mclk);
            rd_chk(SLEEP_STATUS_ADDR, {2'b00, state_tab[i]});
            wake(wake_tab[i]);
            rd_chk(SLEEP_STATUS_ADDR, {2'b00, ST_ACTIVE});
            wr(SLEEP_CONTROL_ADDR, 8'h00);
        end
        $display("sleep modes done");
        for (int i = 0; i < 4; i++) begin
            nap(refuse_tab[i]);
            chk({7'h0, seen_ignored}, 8'h01);
            rd_chk(SLEEP_STATUS_ADDR, {2'b00, ST_ACTIVE});
        end
        $display("refused requests done");
        @(posedge mclk);
        debug_enabled <= 1'b1;
        brownout_sampled_mode <= 1'b1;
        comparator_enabled <= 1'b0;
        nap({4'h0, MODE_FULL_HALT, 1'b1});
        chk({6'h0, power_ctrl.system_osc_run, power_ctrl.brownout_run}, 8'h02);
        chk({6'h0, power_ctrl.vref_keep, power_ctrl.watchdog_run}, 8'h01);
        wake(4'h2);
        $display("debug and brownout done");
        end_of_test();
    end
endmodule : sleep_and_clock_gating_tb

`default_nettype wire
